// ### design/cimb_mask_bank.sv
`timescale 1ns/1ps
`include "cimb_consts.svh"

//Operation
//[R1] Charger mask bit 6 blocks the data-line detection done interrupt pulse.
//[R2] Bit 5 blocks ADC done pulse; the event counts only in one-shot mode.
//[R3] Bit 4 blocks pulses for entering and leaving minimum system regulation.
//[R4] Bit 3 blocks the fast charge timer expiry interrupt.
//[R5] Bit 2 blocks the trickle charge timer expiry interrupt.
//[R6] Bit 1 blocks the pre-charge timer expiry interrupt.
//[R7] Bit 0 blocks the top-off timer expiry interrupt.
//[R8] Temperature mask bit 3 blocks cold threshold crossing interrupts.
//[R9] Bit 2 blocks cool threshold crossing interrupts.
//[R10] Bit 1 blocks warm threshold crossing interrupts.
//[R11] Bit 0 blocks hot threshold crossing interrupts.
//[R12] Temperature masks clear on register reset and watchdog; others on register reset only.
//[R13] Fault mask bit 7 blocks battery current regulation entry and exit interrupts.
//[R14] Bit 6 blocks input bus overvoltage entry interrupts.
//[R15] Bit 5 blocks battery overvoltage entry interrupts.
//[R16] Bit 4 blocks input overcurrent fault interrupts.
//[R17] Bit 3 blocks battery overcurrent fault interrupts.
//[R18] Bit 2 blocks converter overcurrent fault interrupts.
//[R19] Bit 1 blocks second source overvoltage entry interrupts.
//[R20] Bit 0 blocks first source overvoltage entry interrupts.
//[R21] Masks gate only the interrupt; flag updates see every event.
module cimb_mask_bank #(
	// Arbitrary bus address, not taken from any part
	parameter logic [6:0] DEV_ADDR = 7'h3C
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic reg_reset_i,
	input wire logic watchdog_expire_i,
	input wire logic adc_one_shot_i,
	input wire logic [`CIMB_CHARGER_EVENT_COUNT-1:0] ev_charger_i,
	input wire logic [`CIMB_TEMP_EVENT_COUNT-1:0] ev_temp_i,
	input wire logic [`CIMB_FAULT_EVENT_COUNT-1:0] ev_fault_i,
	output logic int_pulse_o,
	output logic [`CIMB_CHARGER_EVENT_COUNT-1:0] flag_charger_o,
	output logic [`CIMB_TEMP_EVENT_COUNT-1:0] flag_temp_o,
	output logic [`CIMB_FAULT_EVENT_COUNT-1:0] flag_fault_o,
	output logic [7:0] charger_event_mask_o,
	output logic [7:0] temperature_zone_mask_o,
	output logic [7:0] protection_fault_mask_o
);
	import cimb_pkg::*;

	logic [1:0] pins_q;
	logic scl_q;
	logic sda_q;
	logic scl_d_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	cimb_state_t state_r;
	cimb_state_t state_nxt;
	logic [3:0] bit_cnt_r;
	logic [3:0] bit_cnt_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [7:0] ptr_r;
	logic [7:0] ptr_nxt;
	logic rw_r;
	logic rw_nxt;
	logic nack_r;
	logic nack_nxt;
	logic drive_low_r;
	logic drive_low_nxt;
	logic wr_en;
	logic byte_done;
	logic addr_match;

	logic [7:0] charger_event_mask_c_r;
	logic [7:0] temperature_zone_mask_r;
	logic [7:0] protection_fault_mask_a_r;
	logic sel_chg;
	logic sel_temp;
	logic sel_fault;
	logic [7:0] rd_data;
	logic [7:0] ptr_inc;

	logic [`CIMB_CHARGER_EVENT_COUNT-1:0] adc_sel;
	logic [`CIMB_CHARGER_EVENT_COUNT-1:0] chg_qualified;
	logic [`CIMB_CHARGER_EVENT_COUNT-1:0] chg_unmasked;
	logic [`CIMB_TEMP_EVENT_COUNT-1:0] temp_unmasked;
	logic [`CIMB_FAULT_EVENT_COUNT-1:0] fault_unmasked;
	logic any_unmasked;
	logic [`CIMB_CHARGER_EVENT_COUNT-1:0] chg_block;
	logic [`CIMB_TEMP_EVENT_COUNT-1:0] temp_block;
	logic [`CIMB_FAULT_EVENT_COUNT-1:0] fault_block;
	logic int_pulse_r;
	logic [`CIMB_CHARGER_EVENT_COUNT-1:0] flag_charger_r;
	logic [`CIMB_TEMP_EVENT_COUNT-1:0] flag_temp_r;
	logic [`CIMB_FAULT_EVENT_COUNT-1:0] flag_fault_r;

	// Pins are asynchronous to clk_i
	cimb_sync #(
		.WIDTH(2),
		.RESET_VAL(`CIMB_BUS_IDLE_LEVEL)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i({scl_i, sda_i}),
		.q_o(pins_q)
	);

	assign scl_q = pins_q[1];
	assign sda_q = pins_q[0];
	assign scl_rise = scl_q & ~scl_d_r;
	assign scl_fall = ~scl_q & scl_d_r;
	assign start_det = scl_q & scl_d_r & sda_d_r & ~sda_q;
	assign stop_det = scl_q & scl_d_r & ~sda_d_r & sda_q;
	assign byte_done = scl_fall & (bit_cnt_r == `CIMB_BITS_PER_BYTE);
	assign addr_match = (shift_r[7:1] == DEV_ADDR);
	assign ptr_inc = ptr_r + `CIMB_PTR_STEP;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_q;
			sda_d_r <= sda_q;
		end
	end

	// Register decode and read mux
	assign sel_chg = (ptr_r == `CIMB_CHARGER_EVENT_MASK_C_OFS);
	assign sel_temp = (ptr_r == `CIMB_TEMPERATURE_ZONE_MASK_OFS);
	assign sel_fault = (ptr_r == `CIMB_PROTECTION_FAULT_MASK_A_OFS);
	// Unmapped offsets read zero and swallow writes, still acknowledged
	assign rd_data = sel_chg ? charger_event_mask_c_r :
		sel_temp ? temperature_zone_mask_r :
		sel_fault ? protection_fault_mask_a_r : 8'h00;

	// Serial slave; no clock stretching, so reads answer from the mux at once
	always_comb begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		rw_nxt = rw_r;
		nack_nxt = nack_r;
		drive_low_nxt = drive_low_r;
		wr_en = 1'b0;
		if (stop_det) begin
			state_nxt = CIMB_IDLE;
			drive_low_nxt = 1'b0;
		end else if (start_det) begin
			state_nxt = CIMB_ADDR;
			bit_cnt_nxt = `CIMB_BIT_CNT_ZERO;
			drive_low_nxt = 1'b0;
		end else begin
			unique case (state_r)
				CIMB_IDLE: begin
				end
				CIMB_ADDR, CIMB_PTR, CIMB_WR: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_q};
						bit_cnt_nxt = bit_cnt_r + `CIMB_BIT_CNT_STEP;
					end else if (byte_done) begin
						bit_cnt_nxt = `CIMB_BIT_CNT_ZERO;
						if (state_r == CIMB_ADDR) begin
							// Foreign address: stay off the bus until next start
							if (addr_match) begin
								rw_nxt = shift_r[0];
								drive_low_nxt = 1'b1;
								state_nxt = CIMB_ACK_ADDR;
							end else begin
								state_nxt = CIMB_IDLE;
							end
						end else if (state_r == CIMB_PTR) begin
							ptr_nxt = shift_r;
							drive_low_nxt = 1'b1;
							state_nxt = CIMB_ACK_PTR;
						end else begin
							wr_en = 1'b1;
							ptr_nxt = ptr_inc;
							drive_low_nxt = 1'b1;
							state_nxt = CIMB_ACK_WR;
						end
					end
				end
				CIMB_ACK_ADDR: begin
					if (scl_fall) begin
						if (rw_r) begin
							shift_nxt = rd_data;
							drive_low_nxt = ~rd_data[7];
							ptr_nxt = ptr_inc;
							state_nxt = CIMB_RD;
						end else begin
							drive_low_nxt = 1'b0;
							state_nxt = CIMB_PTR;
						end
					end
				end
				CIMB_ACK_PTR, CIMB_ACK_WR: begin
					if (scl_fall) begin
						drive_low_nxt = 1'b0;
						state_nxt = CIMB_WR;
					end
				end
				CIMB_RD: begin
					if (scl_rise) begin
						bit_cnt_nxt = bit_cnt_r + `CIMB_BIT_CNT_STEP;
					end else if (byte_done) begin
						bit_cnt_nxt = `CIMB_BIT_CNT_ZERO;
						drive_low_nxt = 1'b0;
						state_nxt = CIMB_ACK_RD;
					end else if (scl_fall) begin
						shift_nxt = {shift_r[6:0], 1'b0};
						drive_low_nxt = ~shift_r[6];
					end
				end
				CIMB_ACK_RD: begin
					if (scl_rise) begin
						nack_nxt = sda_q;
					end else if (scl_fall) begin
						if (nack_r) begin
							state_nxt = CIMB_IDLE;
						end else begin
							shift_nxt = rd_data;
							drive_low_nxt = ~rd_data[7];
							ptr_nxt = ptr_inc;
							state_nxt = CIMB_RD;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r <= CIMB_IDLE;
			bit_cnt_r <= `CIMB_BIT_CNT_ZERO;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			drive_low_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
			rw_r <= rw_nxt;
			nack_r <= nack_nxt;
			drive_low_r <= drive_low_nxt;
		end
	end

	// Open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~drive_low_r;

	// Mask registers; a reset in the same cycle beats a write
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || reg_reset_i) begin
			charger_event_mask_c_r <= `CIMB_CHARGER_EVENT_MASK_C_RST; // [R12]
		end else if (wr_en && sel_chg) begin
			charger_event_mask_c_r <= shift_r & `CIMB_CHARGER_EVENT_MASK_C_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || reg_reset_i || watchdog_expire_i) begin
			temperature_zone_mask_r <= `CIMB_TEMPERATURE_ZONE_MASK_RST; // [R12]
		end else if (wr_en && sel_temp) begin
			temperature_zone_mask_r <= shift_r & `CIMB_TEMPERATURE_ZONE_MASK_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || reg_reset_i) begin
			protection_fault_mask_a_r <= `CIMB_PROTECTION_FAULT_MASK_A_RST; // [R12]
		end else if (wr_en && sel_fault) begin
			protection_fault_mask_a_r <= shift_r & `CIMB_PROTECTION_FAULT_MASK_A_WMASK;
		end
	end

	// Fields gathered by name, so a moved bit shows up in one place
	assign chg_block = {
		charger_event_mask_c_r[`CIMB_DATALINE_DETECT_DONE_IRQ_BLOCK_BIT], // [R1]
		charger_event_mask_c_r[`CIMB_ADC_DONE_IRQ_BLOCK_BIT], // [R2]
		charger_event_mask_c_r[`CIMB_MIN_SYSTEM_REG_IRQ_BLOCK_BIT], // [R3]
		charger_event_mask_c_r[`CIMB_FAST_TIMER_IRQ_BLOCK_BIT], // [R4]
		charger_event_mask_c_r[`CIMB_TRICKLE_TIMER_IRQ_BLOCK_BIT], // [R5]
		charger_event_mask_c_r[`CIMB_PRECHARGE_TIMER_IRQ_BLOCK_BIT], // [R6]
		charger_event_mask_c_r[`CIMB_TOPOFF_TIMER_IRQ_BLOCK_BIT] // [R7]
	};
	assign temp_block = {
		temperature_zone_mask_r[`CIMB_THERMISTOR_COLD_IRQ_BLOCK_BIT], // [R8]
		temperature_zone_mask_r[`CIMB_THERMISTOR_COOL_IRQ_BLOCK_BIT], // [R9]
		temperature_zone_mask_r[`CIMB_THERMISTOR_WARM_IRQ_BLOCK_BIT], // [R10]
		temperature_zone_mask_r[`CIMB_THERMISTOR_HOT_IRQ_BLOCK_BIT] // [R11]
	};
	assign fault_block = {
		protection_fault_mask_a_r[`CIMB_BATTERY_CURRENT_REG_IRQ_BLOCK_BIT], // [R13]
		protection_fault_mask_a_r[`CIMB_INPUT_BUS_OVERVOLT_IRQ_BLOCK_BIT], // [R14]
		protection_fault_mask_a_r[`CIMB_BATTERY_OVERVOLT_IRQ_BLOCK_BIT], // [R15]
		protection_fault_mask_a_r[`CIMB_INPUT_OVERCURRENT_IRQ_BLOCK_BIT], // [R16]
		protection_fault_mask_a_r[`CIMB_BATTERY_OVERCURRENT_IRQ_BLOCK_BIT], // [R17]
		protection_fault_mask_a_r[`CIMB_CONVERTER_OVERCURRENT_IRQ_BLOCK_BIT], // [R18]
		protection_fault_mask_a_r[`CIMB_SECOND_SOURCE_OVERVOLT_IRQ_BLOCK_BIT], // [R19]
		protection_fault_mask_a_r[`CIMB_FIRST_SOURCE_OVERVOLT_IRQ_BLOCK_BIT] // [R20]
	};

	// ADC done only counts while the converter runs one-shot
	assign adc_sel = `CIMB_CHARGER_EVENT_COUNT'(1) << `CIMB_ADC_DONE_IRQ_BLOCK_BIT; // [R2]
	assign chg_qualified = ev_charger_i & ~(adc_sel & ~{`CIMB_CHARGER_EVENT_COUNT{adc_one_shot_i}});
	// Event inputs are single-cycle; two-way events arrive as one pulse per edge
	assign chg_unmasked = chg_qualified &
		~chg_block; // [R1] [R2] [R3] [R4] [R5] [R6] [R7]
	assign temp_unmasked = ev_temp_i &
		~temp_block; // [R8] [R9] [R10] [R11]
	assign fault_unmasked = ev_fault_i &
		~fault_block; // [R13] [R14] [R15] [R16] [R17] [R18] [R19] [R20]
	assign any_unmasked = |{chg_unmasked, temp_unmasked, fault_unmasked};

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			int_pulse_r <= 1'b0;
			flag_charger_r <= '0;
			flag_temp_r <= '0;
			flag_fault_r <= '0;
		end else begin
			int_pulse_r <= any_unmasked;
			// Flag side sees raw events regardless of masks
			flag_charger_r <= ev_charger_i; // [R21]
			flag_temp_r <= ev_temp_i; // [R21]
			flag_fault_r <= ev_fault_i; // [R21]
		end
	end

	assign int_pulse_o = int_pulse_r;
	assign flag_charger_o = flag_charger_r;
	assign flag_temp_o = flag_temp_r;
	assign flag_fault_o = flag_fault_r;
	assign charger_event_mask_o = charger_event_mask_c_r;
	assign temperature_zone_mask_o = temperature_zone_mask_r;
	assign protection_fault_mask_o = protection_fault_mask_a_r;

endmodule // cimb_mask_bank

// ### design/cimb_consts.svh
`ifndef CIMB_CONSTS_SVH
`define CIMB_CONSTS_SVH

// Register offsets on the serial bus
`define CIMB_CHARGER_EVENT_MASK_C_OFS 8'h2A
`define CIMB_TEMPERATURE_ZONE_MASK_OFS 8'h2B
`define CIMB_PROTECTION_FAULT_MASK_A_OFS 8'h2C

// Reset values
`define CIMB_CHARGER_EVENT_MASK_C_RST 8'h00
`define CIMB_TEMPERATURE_ZONE_MASK_RST 8'h00
`define CIMB_PROTECTION_FAULT_MASK_A_RST 8'h00

// Writable bits; the rest read as zero
`define CIMB_CHARGER_EVENT_MASK_C_WMASK 8'h7F
`define CIMB_TEMPERATURE_ZONE_MASK_WMASK 8'h0F
`define CIMB_PROTECTION_FAULT_MASK_A_WMASK 8'hFF

// Charger event mask fields
`define CIMB_DATALINE_DETECT_DONE_IRQ_BLOCK_BIT 6
`define CIMB_ADC_DONE_IRQ_BLOCK_BIT 5
`define CIMB_MIN_SYSTEM_REG_IRQ_BLOCK_BIT 4
`define CIMB_FAST_TIMER_IRQ_BLOCK_BIT 3
`define CIMB_TRICKLE_TIMER_IRQ_BLOCK_BIT 2
`define CIMB_PRECHARGE_TIMER_IRQ_BLOCK_BIT 1
`define CIMB_TOPOFF_TIMER_IRQ_BLOCK_BIT 0
`define CIMB_CHARGER_EVENT_COUNT 7

// Temperature zone mask fields
`define CIMB_THERMISTOR_COLD_IRQ_BLOCK_BIT 3
`define CIMB_THERMISTOR_COOL_IRQ_BLOCK_BIT 2
`define CIMB_THERMISTOR_WARM_IRQ_BLOCK_BIT 1
`define CIMB_THERMISTOR_HOT_IRQ_BLOCK_BIT 0
`define CIMB_TEMP_EVENT_COUNT 4

// Protection fault mask fields
`define CIMB_BATTERY_CURRENT_REG_IRQ_BLOCK_BIT 7
`define CIMB_INPUT_BUS_OVERVOLT_IRQ_BLOCK_BIT 6
`define CIMB_BATTERY_OVERVOLT_IRQ_BLOCK_BIT 5
`define CIMB_INPUT_OVERCURRENT_IRQ_BLOCK_BIT 4
`define CIMB_BATTERY_OVERCURRENT_IRQ_BLOCK_BIT 3
`define CIMB_CONVERTER_OVERCURRENT_IRQ_BLOCK_BIT 2
`define CIMB_SECOND_SOURCE_OVERVOLT_IRQ_BLOCK_BIT 1
`define CIMB_FIRST_SOURCE_OVERVOLT_IRQ_BLOCK_BIT 0
`define CIMB_FAULT_EVENT_COUNT 8

// Serial framing
`define CIMB_BITS_PER_BYTE 4'h8
`define CIMB_BIT_CNT_ZERO 4'h0
`define CIMB_BIT_CNT_STEP 4'h1
`define CIMB_PTR_STEP 8'h01
`define CIMB_BUS_IDLE_LEVEL 2'h3

`endif

// ### design/cimb_pkg.sv
package cimb_pkg;

	typedef enum logic [3:0] {
		CIMB_IDLE = 4'b0000,
		CIMB_ADDR = 4'b0001,
		CIMB_ACK_ADDR = 4'b0010,
		CIMB_PTR = 4'b0011,
		CIMB_ACK_PTR = 4'b0100,
		CIMB_WR = 4'b0101,
		CIMB_ACK_WR = 4'b0110,
		CIMB_RD = 4'b0111,
		CIMB_ACK_RD = 4'b1000
	} cimb_state_t;

endpackage

// ### design/cimb_sync.sv
`timescale 1ns/1ps

module cimb_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	import cimb_pkg::*;

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic ff1_r;
			logic ff2_r;
			logic ff3_r;
			logic q_r;
			// Level only moves once the second and third stages agree
			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					ff1_r <= RESET_VAL[gi];
					ff2_r <= RESET_VAL[gi];
					ff3_r <= RESET_VAL[gi];
					q_r <= RESET_VAL[gi];
				end else begin
					ff1_r <= d_i[gi];
					ff2_r <= ff1_r;
					ff3_r <= ff2_r;
					if (ff2_r == ff3_r) begin
						q_r <= ff3_r;
					end
				end
			end
			assign q_o[gi] = q_r;
		end
	endgenerate

endmodule // cimb_sync

// ### verification/cimb_host_model.sv
`timescale 1ns/1ps

module cimb_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h3C
) (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// Open drain: 1 releases the line to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic half();
		repeat (8) @(posedge clk_i);
	endtask
	// Also serves as repeated start from SCL low
	task automatic start();
		sda_o <= 1'b1;
		half();
		scl_o <= 1'b1;
		half();
		sda_o <= 1'b0;
		half();
		scl_o <= 1'b0;
		half();
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		half();
		scl_o <= 1'b1;
		half();
		sda_o <= 1'b1;
		half();
	endtask
	// Data moves only mid SCL low, so the pin filter never sees a false start
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic ack);
		logic [8:0] b;
		b = {d, last};
		for (int i = 8; i >= 0; i--) begin
			sda_o <= b[i];
			half();
			scl_o <= 1'b1;
			half();
			b[i] = sda_i;
			scl_o <= 1'b0;
			half();
		end
		r = b[8:1];
		ack = !b[0];
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic k0, k1, k2;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer(a, 1'b1, r, k1);
		xfer(d, 1'b1, r, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic k0, k1, k2, kx;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, d, k0);
		xfer(a, 1'b1, d, k1);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, d, k2);
		xfer(8'hFF, 1'b1, d, kx);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule // cimb_host_model

// ### verification/cimb_checker.sv
`timescale 1ns/1ps
`include "cimb_consts.svh"

module cimb_checker (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic reg_reset_i,
	input wire logic watchdog_expire_i,
	input wire logic adc_one_shot_i,
	input wire logic [`CIMB_CHARGER_EVENT_COUNT-1:0] ev_charger_i,
	input wire logic [`CIMB_TEMP_EVENT_COUNT-1:0] ev_temp_i,
	input wire logic [`CIMB_FAULT_EVENT_COUNT-1:0] ev_fault_i,
	input wire logic int_pulse_o,
	input wire logic [`CIMB_CHARGER_EVENT_COUNT-1:0] flag_charger_o,
	input wire logic [`CIMB_TEMP_EVENT_COUNT-1:0] flag_temp_o,
	input wire logic [`CIMB_FAULT_EVENT_COUNT-1:0] flag_fault_o,
	input wire logic [7:0] charger_event_mask_o,
	input wire logic [7:0] temperature_zone_mask_o,
	input wire logic [7:0] protection_fault_mask_o
);
	wire logic hit_w;
	// ADC done counts only in one-shot mode
	assign hit_w = |(ev_charger_i & ~charger_event_mask_o[6:0] & {1'b1, adc_one_shot_i, 5'h1F})
		| |(ev_temp_i & ~temperature_zone_mask_o[3:0]) | |(ev_fault_i & ~protection_fault_mask_o);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	charger_pulse_a: assert property (
		|(ev_charger_i & ~charger_event_mask_o[6:0] & 7'h5F) |=> int_pulse_o)
		else $error("charger event lost");
	adc_pulse_a: assert property (
		ev_charger_i[5] && !charger_event_mask_o[5] && adc_one_shot_i |=> int_pulse_o)
		else $error("adc done lost");
	temp_pulse_a: assert property (
		|(ev_temp_i & ~temperature_zone_mask_o[3:0]) |=> int_pulse_o)
		else $error("temp event lost");
	fault_pulse_a: assert property (
		|(ev_fault_i & ~protection_fault_mask_o) |=> int_pulse_o)
		else $error("fault event lost");
	masked_quiet_a: assert property (int_pulse_o |-> $past(hit_w))
		else $error("pulse without unmasked event");
	raw_flags_a: assert property (1'b1 |=> {flag_charger_o, flag_temp_o, flag_fault_o}
		== $past({ev_charger_i, ev_temp_i, ev_fault_i})) else $error("flag gated");
	reg_clear_a: assert property (reg_reset_i |=> charger_event_mask_o == 8'h00 &&
		temperature_zone_mask_o == 8'h00 && protection_fault_mask_o == 8'h00)
		else $error("masks kept on reset");
	wdog_clear_a: assert property (watchdog_expire_i && !reg_reset_i |=>
		temperature_zone_mask_o == 8'h00 && charger_event_mask_o == $past(charger_event_mask_o)
		&& protection_fault_mask_o == $past(protection_fault_mask_o))
		else $error("watchdog clear wrong");
	reserved_zero_a: assert property (charger_event_mask_o[7] == 1'b0 &&
		temperature_zone_mask_o[7:4] == 4'h0) else $error("reserved bit set");
endmodule // cimb_checker

bind cimb_mask_bank cimb_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.reg_reset_i(reg_reset_i), .watchdog_expire_i(watchdog_expire_i),
	.adc_one_shot_i(adc_one_shot_i), .ev_charger_i(ev_charger_i), .ev_temp_i(ev_temp_i),
	.ev_fault_i(ev_fault_i), .int_pulse_o(int_pulse_o), .flag_charger_o(flag_charger_o),
	.flag_temp_o(flag_temp_o), .flag_fault_o(flag_fault_o),
	.charger_event_mask_o(charger_event_mask_o), .temperature_zone_mask_o(temperature_zone_mask_o),
	.protection_fault_mask_o(protection_fault_mask_o));

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "cimb_consts.svh"
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: %s", $time, m); end end

module testbench;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic reg_reset_i = 1'b0;
	logic watchdog_expire_i = 1'b0;
	logic adc_one_shot_i = 1'b0;
	logic [6:0] ev_charger_i = 7'h00;
	logic [3:0] ev_temp_i = 4'h0;
	logic [7:0] ev_fault_i = 8'h00;
	logic scl_w, sda_host_w, sda_wire_w, sda_o_w, sda_oe_n_w, int_pulse_w, ok;
	logic [6:0] flag_c_w;
	logic [3:0] flag_t_w;
	logic [7:0] flag_f_w, d;
	logic [7:0] mask_w [3];
	logic [7:0] ofs [3] = '{`CIMB_CHARGER_EVENT_MASK_C_OFS, `CIMB_TEMPERATURE_ZONE_MASK_OFS,
		`CIMB_PROTECTION_FAULT_MASK_A_OFS};
	logic [7:0] wm [3] = '{`CIMB_CHARGER_EVENT_MASK_C_WMASK, `CIMB_TEMPERATURE_ZONE_MASK_WMASK,
		`CIMB_PROTECTION_FAULT_MASK_A_WMASK};
	int m [3] = '{0, 0, 0};
	int miscompares = 0;
	int n_checks = 0;
	int seed = 32'hB485;
	always #5 clk_i = ~clk_i;
	// Pull-up on SDA; either party may pull it low
	assign sda_wire_w = sda_host_w & (sda_oe_n_w | sda_o_w);
	cimb_host_model host (.clk_i(clk_i), .sda_i(sda_wire_w), .scl_o(scl_w), .sda_o(sda_host_w));
	cimb_mask_bank uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_w), .sda_i(sda_wire_w),
		.sda_o(sda_o_w), .sda_oe_n_o(sda_oe_n_w), .reg_reset_i(reg_reset_i),
		.watchdog_expire_i(watchdog_expire_i), .adc_one_shot_i(adc_one_shot_i),
		.ev_charger_i(ev_charger_i), .ev_temp_i(ev_temp_i), .ev_fault_i(ev_fault_i),
		.int_pulse_o(int_pulse_w), .flag_charger_o(flag_c_w), .flag_temp_o(flag_t_w),
		.flag_fault_o(flag_f_w), .charger_event_mask_o(mask_w[0]),
		.temperature_zone_mask_o(mask_w[1]), .protection_fault_mask_o(mask_w[2]));
	task automatic wrm(input int i, input logic [7:0] v);
		host.wr(ofs[i], v, ok);
		`CHK(ok, 1'b1, "write not acked")
		m[i] = v & wm[i];
	endtask
	task automatic check_reg(input int i);
		host.rd(ofs[i], d, ok);
		`CHK(d, 8'(m[i]), "readback")
		`CHK(mask_w[i], 8'(m[i]), "mask output")
	endtask
	// One event at a time so each mask bit is judged alone
	task automatic run_events(input int n);
		logic [18:0] ev, mw;
		logic adc, exp_int;
		for (int j = 0; j < n; j++) begin
			ev = 19'h1 << ($unsigned($random(seed)) % 19);
			adc = 1'($random(seed));
			mw = {7'(m[0]), 4'(m[1]), 8'(m[2])};
			exp_int = |(ev & ~mw) && !(ev[17] && !adc);
			@(posedge clk_i);
			{ev_charger_i, ev_temp_i, ev_fault_i} <= ev;
			adc_one_shot_i <= adc;
			@(posedge clk_i);
			{ev_charger_i, ev_temp_i, ev_fault_i} <= 19'h0;
			#1;
			if (|ev[18:12]) `CHK(int_pulse_w, exp_int, "chg irq")
			else if (|ev[11:8]) `CHK(int_pulse_w, exp_int, "temp irq")
			else `CHK(int_pulse_w, exp_int, "flt irq")
			`CHK({flag_c_w, flag_t_w, flag_f_w}, ev, "event flags")
		end
	endtask
	task automatic finish_test();
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 3; i++) check_reg(i);
		run_events(40);
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 3; i++) wrm(i, 8'($random(seed)));
			for (int i = 0; i < 3; i++) check_reg(i);
			run_events(60);
		end
		// Unmapped place: acked, dropped, reads zero
		host.wr(8'h2D, 8'hFF, ok);
		`CHK(ok, 1'b1, "unmapped write not acked")
		host.rd(8'h2D, d, ok);
		`CHK(d, 8'h00, "unmapped read")
		for (int i = 0; i < 3; i++) wrm(i, 8'hFF);
		run_events(20);
		@(posedge clk_i);
		watchdog_expire_i <= 1'b1;
		@(posedge clk_i);
		watchdog_expire_i <= 1'b0;
		m[1] = 0;
		for (int i = 0; i < 3; i++) check_reg(i);
		@(posedge clk_i);
		reg_reset_i <= 1'b1;
		@(posedge clk_i);
		reg_reset_i <= 1'b0;
		m = '{0, 0, 0};
		for (int i = 0; i < 3; i++) check_reg(i);
		finish_test();
	end
	// Whole run is about 28k cycles
	initial begin
		#800000;
		miscompares++;
		finish_test();
	end
endmodule // testbench
